// *** hdl/iotr_defs.vh ***
`ifndef IOTR_DEFS_VH
`define IOTR_DEFS_VH

// Register byte offsets on the Avalon-MM slave.
`define IOTR_CTRL_OFS       4'h0
`define IOTR_STATUS_OFS     4'h4

// Control register fields.
`define IOTR_CTRL_CE        0
`define IOTR_CTRL_DDR       1
`define IOTR_CTRL_DLATCH    2
`define IOTR_CTRL_OLATCH    3
`define IOTR_CTRL_SRST      4
`define IOTR_CTRL_RESET     32'h0000_0000

// Status register fields.
`define IOTR_STAT_DATA      0
`define IOTR_STAT_OE        1
`define IOTR_STAT_CNT_LO    2
`define IOTR_STAT_CNT_HI    3
`define IOTR_STAT_READY     4
`define IOTR_STAT_CE        5

// Word layout inside the elastic buffer.
`define IOTR_W_DPRI         0
`define IOTR_W_DSEC         1
`define IOTR_W_OPRI         2
`define IOTR_W_OSEC         3
`define IOTR_WORD_W         4
`define IOTR_BUF_DEPTH      2

`endif

// *** hdl/iotr_buf2.v ***
`timescale 1ns/10ps
`include "iotr_defs.vh"

module iotr_buf2 #(
    parameter WIDTH = `IOTR_WORD_W
) (
    // Clock and reset.
    input  wire             i_clk,
    input  wire             i_rst_n,
    // Filling side.
    input  wire [WIDTH-1:0] i_data,
    input  wire             i_valid,
    output wire             o_ready,
    // Draining side.
    output wire [WIDTH-1:0] o_data,
    output wire             o_valid,
    input  wire             i_ready,
    // Fill level.
    output wire [1:0]       o_count
);

    reg [WIDTH-1:0] mem_reg [0:1];
    reg             wr_ptr_reg;
    reg             rd_ptr_reg;
    reg [1:0]       count_reg;
    wire            push;
    wire            pop;

    assign o_ready = (count_reg != 2'h2);
    assign o_valid = (count_reg != 2'h0);
    assign o_data  = mem_reg[rd_ptr_reg];
    assign o_count = count_reg;
    assign push    = i_valid & o_ready;
    assign pop     = o_valid & i_ready;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mem_reg[0] <= {WIDTH{1'b0}};
            mem_reg[1] <= {WIDTH{1'b0}};
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) begin
                mem_reg[wr_ptr_reg] <= i_data;
                wr_ptr_reg          <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 2'h1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 2'h1;
            end
        end
    end

endmodule // iotr_buf2

// *** hdl/iotr_out_stage.v ***
// What this block does
// RULE1: Core signals are registered before reaching the pad.
// RULE2: SDR mode drives pad from one storage element.
// RULE3: SDR element selectable as flip-flop or latch.
// RULE4: DDR registers primary on rise, latches secondary.
// RULE5: Secondary latch passes while control low, holds otherwise.
// RULE6: Clock-driven multiplexer picks the phase for the pad.
// RULE7: SDR register has reset and clock enable.
// RULE8: Extra DDR latch has no reset or enable.
// RULE9: Enable control is registered before the pad buffer.
// RULE10: SDR enable path uses one flip-flop or latch.
// RULE11: DDR enable: primary registered, secondary latched.
// RULE12: Clock-driven multiplexer picks the enable phase.
// RULE13: Rate and latch modes are static while running.
//
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "iotr_defs.vh"

module iotr_out_stage (
    // Clock and reset.
    input  wire        i_clk,
    input  wire        i_rst_n,
    // Avalon-MM slave.
    input  wire [3:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    input  wire [3:0]  i_avs_byteenable,
    output reg  [31:0] o_avs_readdata,
    output wire        o_avs_waitrequest,
    // Word stream from core logic.
    input  wire        i_out_data_primary,
    input  wire        i_out_data_secondary,
    input  wire        i_oe_primary,
    input  wire        i_oe_secondary,
    input  wire        i_word_valid,
    output wire        o_word_ready,
    // Pad buffer.
    output wire        o_pad_drive_out,
    output wire        o_pad_oe
);

    // Control register and bus handshake.
    reg        ctrl_ce_reg;
    reg        ctrl_ddr_reg;
    reg        ctrl_dlatch_reg;
    reg        ctrl_olatch_reg;
    reg        ctrl_srst_reg;
    reg        ack_reg;
    reg [31:0] rdata_next;

    // Buffer signals.
    wire [`IOTR_WORD_W-1:0] buf_in;
    wire [`IOTR_WORD_W-1:0] head;
    wire                    head_valid;
    wire [1:0]              buf_count;
    wire                    take;

    // Storage elements of the two stages.
    reg  dpri_reg;
    reg  dsec_hold_reg;
    reg  dsec_lat;
    reg  dsdr_lat;
    reg  opri_reg;
    reg  osec_hold_reg;
    reg  osec_lat;
    reg  osdr_lat;

    wire bus_req;
    wire hit_ctrl;
    wire hit_stat;
    wire wr_ctrl;

    // Reset image of the control word, split into its bits below.
    localparam [31:0] CTRL_RST = `IOTR_CTRL_RESET;

    function sel_phase;
        input ddr;
        input lat_mode;
        input clk_lvl;
        input pri_q;
        input sec_q;
        input lat_q;
        begin
            if (ddr) begin
                sel_phase = clk_lvl ? pri_q : sec_q;
            end else begin
                sel_phase = lat_mode ? lat_q : pri_q;
            end
        end
    endfunction

    // Every access is answered on the cycle after it is first seen.
    assign bus_req           = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = bus_req & ~ack_reg;
    assign hit_ctrl          = (i_avs_address == `IOTR_CTRL_OFS);
    assign hit_stat          = (i_avs_address == `IOTR_STATUS_OFS);
    // A write lands on the edge that closes its acknowledged cycle, one after its wait state ends.
    assign wr_ctrl           = i_avs_write & ack_reg & hit_ctrl
                               & i_avs_byteenable[0];

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
        end
    end

    always @* begin
        rdata_next = 32'h0000_0000;
        if (hit_ctrl) begin
            rdata_next[`IOTR_CTRL_CE]     = ctrl_ce_reg;
            rdata_next[`IOTR_CTRL_DDR]    = ctrl_ddr_reg;
            rdata_next[`IOTR_CTRL_DLATCH] = ctrl_dlatch_reg;
            rdata_next[`IOTR_CTRL_OLATCH] = ctrl_olatch_reg;
            rdata_next[`IOTR_CTRL_SRST]   = ctrl_srst_reg;
        end else if (hit_stat) begin
            // The live pad flips with the clock in DDR mode and would race
            // the edge that samples it, so the low-half value is reported.
            rdata_next[`IOTR_STAT_DATA]   = sel_phase(ctrl_ddr_reg,
                                            ctrl_dlatch_reg, 1'b0,
                                            dpri_reg, dsec_lat, dsdr_lat);
            rdata_next[`IOTR_STAT_OE]     = sel_phase(ctrl_ddr_reg,
                                            ctrl_olatch_reg, 1'b0,
                                            opri_reg, osec_lat, osdr_lat);
            rdata_next[`IOTR_STAT_CNT_HI:`IOTR_STAT_CNT_LO] = buf_count;
            rdata_next[`IOTR_STAT_READY]  = o_word_ready;
            rdata_next[`IOTR_STAT_CE]     = ctrl_ce_reg;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_avs_read && !ack_reg) begin
            o_avs_readdata <= rdata_next;
        end
    end

    // Mode bits only change while the stage is stopped, so the pad never
    // sees a half-switched path.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_ce_reg     <= CTRL_RST[`IOTR_CTRL_CE];
            ctrl_ddr_reg    <= CTRL_RST[`IOTR_CTRL_DDR];
            ctrl_dlatch_reg <= CTRL_RST[`IOTR_CTRL_DLATCH];
            ctrl_olatch_reg <= CTRL_RST[`IOTR_CTRL_OLATCH];
            ctrl_srst_reg   <= CTRL_RST[`IOTR_CTRL_SRST];
        end else if (wr_ctrl) begin
            ctrl_ce_reg   <= i_avs_writedata[`IOTR_CTRL_CE];
            ctrl_srst_reg <= i_avs_writedata[`IOTR_CTRL_SRST];
            if (!ctrl_ce_reg) begin // [RULE13]
                ctrl_ddr_reg    <= i_avs_writedata[`IOTR_CTRL_DDR];
                ctrl_dlatch_reg <= i_avs_writedata[`IOTR_CTRL_DLATCH];
                ctrl_olatch_reg <= i_avs_writedata[`IOTR_CTRL_OLATCH];
            end
        end
    end

    // Incoming words wait here; a cleared enable stalls the core.
    assign buf_in = {i_oe_secondary, i_oe_primary,
                     i_out_data_secondary, i_out_data_primary};

    iotr_buf2 #(
        .WIDTH (`IOTR_WORD_W)
    ) u_buf (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_data  (buf_in),
        .i_valid (i_word_valid),
        .o_ready (o_word_ready),
        .o_data  (head),
        .o_valid (head_valid),
        .i_ready (take),
        .o_count (buf_count)
    ); // [RULE1]

    assign take = head_valid & ctrl_ce_reg & ~ctrl_srst_reg; // [RULE7]

    // Primary flip-flops: SDR register and DDR rising-edge register.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dpri_reg <= 1'b0;
            opri_reg <= 1'b0;
        end else if (ctrl_srst_reg) begin
            dpri_reg <= 1'b0; // [RULE7]
            opri_reg <= 1'b0;
        end else if (take) begin
            dpri_reg <= head[`IOTR_W_DPRI]; // [RULE2] [RULE4]
            opri_reg <= head[`IOTR_W_OPRI]; // [RULE9] [RULE11]
        end
    end

    // Secondary phase is held with its word so the low half stays aligned.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dsec_hold_reg <= 1'b0;
            osec_hold_reg <= 1'b0;
        end else if (take) begin
            dsec_hold_reg <= head[`IOTR_W_DSEC];
            osec_hold_reg <= head[`IOTR_W_OSEC];
        end
    end

    // DDR secondary latches: open while the clock is low, no reset.
    always @(i_clk or dsec_hold_reg) begin
        if (!i_clk) begin
            dsec_lat <= dsec_hold_reg; // [RULE4] [RULE5] [RULE8]
        end
    end

    always @(i_clk or osec_hold_reg) begin
        if (!i_clk) begin
            osec_lat <= osec_hold_reg; // [RULE11] [RULE5] [RULE8]
        end
    end

    // SDR latch form: open while the clock is low and the stage takes,
    // closing on the rising edge that pops the same word.
    always @(i_clk or i_rst_n or ctrl_srst_reg or take or head) begin
        if (!i_rst_n || ctrl_srst_reg) begin
            dsdr_lat <= 1'b0; // [RULE7]
            osdr_lat <= 1'b0;
        end else if (!i_clk && take) begin
            dsdr_lat <= head[`IOTR_W_DPRI]; // [RULE3]
            osdr_lat <= head[`IOTR_W_OPRI]; // [RULE10]
        end
    end

    // The clock level itself steers the phase select in DDR mode.
    assign o_pad_drive_out = sel_phase(ctrl_ddr_reg, ctrl_dlatch_reg, i_clk,
                                       dpri_reg, dsec_lat,
                                       dsdr_lat); // [RULE6] [RULE2] [RULE3]
    assign o_pad_oe        = sel_phase(ctrl_ddr_reg, ctrl_olatch_reg, i_clk,
                                       opri_reg, osec_lat,
                                       osdr_lat); // [RULE12] [RULE10]

endmodule // iotr_out_stage

// *** tb/iotr_core_src.sv ***
`timescale 1ns/10ps
module iotr_core_src (
    // Core side of the word stream.
    input  wire logic       i_clk,
    input  wire logic       i_ready,
    output logic      [3:0] o_word,
    output logic            o_valid
);
    logic [3:0] q[$];
    task automatic push(input logic [3:0] w);
        q.push_back(w);
    endtask
    initial {o_valid, o_word} = 5'h00;
    // Idle words are inverted each cycle so stale data cannot pass as good.
    always @(posedge i_clk) begin
        if (o_valid && i_ready) begin
            void'(q.pop_front());
        end
        o_valid <= (q.size() != 0);
        o_word  <= (q.size() != 0) ? q[0] : ~o_word;
    end
endmodule // iotr_core_src

// *** tb/iotr_out_stage_chk.sv ***
`timescale 1ns/10ps
module iotr_chk (
    // Watched ports.
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic [3:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic        i_word_valid,
    input wire logic        o_word_ready,
    input wire logic        o_pad_drive_out,
    input wire logic        o_pad_oe
);
    // Control bits are mirrored here, as the checker cannot see inside.
    logic ce_reg, ddr_reg, dl_reg, ol_reg, srst_reg;
    wire  take = i_avs_write && !o_avs_waitrequest &&
                 i_avs_address == 4'h0 && i_avs_byteenable[0];
    wire  sdr_ff = !ddr_reg && !dl_reg && !ol_reg;
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {ce_reg, ddr_reg, dl_reg, ol_reg, srst_reg} <= 5'h00;
        end else if (take) begin
            ce_reg   <= i_avs_writedata[0];
            srst_reg <= i_avs_writedata[4];
            if (!ce_reg) begin
                {ol_reg, dl_reg, ddr_reg} <= i_avs_writedata[3:1];
            end
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wait_one_a: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=>
        !o_avs_waitrequest) else $error("wait not ended");
    wait_first_a: assert property (
        $rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
        else $error("no wait on first cycle");
    unmapped_zero_a: assert property (
        i_avs_read && !o_avs_waitrequest && i_avs_address != 4'h0 &&
        i_avs_address != 4'h4 |-> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (
        i_avs_read && !o_avs_waitrequest |=> $stable(o_avs_readdata))
        else $error("read data moved");
    stall_hold_a: assert property (
        !ce_reg && !srst_reg && sdr_ff && !i_avs_write |=>
        $stable({o_pad_oe, o_pad_drive_out})) else $error("pad moved");
    srst_clear_a: assert property (
        srst_reg && sdr_ff && !i_avs_write |=>
        {o_pad_oe, o_pad_drive_out} == 2'b00) else $error("pad not cleared");
    full_stall_a: assert property (
        !o_word_ready && (!ce_reg || srst_reg) |=> !o_word_ready)
        else $error("stalled buffer drained");
    ready_fall_a: assert property (
        $fell(o_word_ready) |-> $past(i_word_valid))
        else $error("ready fell without a word");
    cover property (ce_reg && ddr_reg);
    cover property (!o_word_ready);
    cover property (srst_reg && ce_reg);
endmodule // iotr_chk
bind iotr_out_stage iotr_chk i_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_word_valid(i_word_valid),
    .o_word_ready(o_word_ready), .o_pad_drive_out(o_pad_drive_out),
    .o_pad_oe(o_pad_oe));

// *** tb/iotr_out_stage_tb_top.sv ***
`timescale 1ns/10ps
module iotr_out_stage_tb_top;
    logic        i_clk, i_rst_n, rd, wr, valid;
    logic [3:0]  addr, word, be;
    logic [31:0] wdata, r;
    wire  [31:0] rdata;
    wire         wreq, rdy, pd, poe;
    int          failures, samples_checked, cyc;
    logic [3:0]  dw[2] = '{4'h9, 4'h6};
    iotr_out_stage i_dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .i_out_data_primary(word[0]),
        .i_out_data_secondary(word[1]), .i_oe_primary(word[2]),
        .i_oe_secondary(word[3]), .i_word_valid(valid), .o_word_ready(rdy),
        .o_pad_drive_out(pd), .o_pad_oe(poe));
    iotr_core_src i_src (.i_clk(i_clk), .i_ready(rdy), .o_word(word),
        .o_valid(valid));
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    task automatic end_of_test;
        if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        samples_checked++;
        if (e !== g) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic pad(input logic [1:0] e, input string n);
        chk(n, {30'h0, e}, {30'h0, poe, pd});
    endtask
    task automatic acc(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge i_clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do @(posedge i_clk); while (wreq !== 1'b0);
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e,
                       input string n);
        acc(1'b0, a, 32'h0);
        chk(n, e, r);
    endtask
    task automatic put(input logic [3:0] w);
        @(negedge i_clk);
        i_src.push(w);
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc > 2000) begin
            failures++;
            end_of_test;
        end
    end
    initial begin
        {i_rst_n, rd, wr, addr, wdata} = '0;
        be = 4'hf;
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rdc(4'h4, 32'h10, "status");
        acc(1'b1, 4'h8, 32'hffff_ffff);
        rdc(4'h8, 32'h0, "unmapped");
        rdc(4'h0, 32'h0, "ctrl");
        be <= 4'h0;
        acc(1'b1, 4'h0, 32'h1);
        be <= 4'hf;
        rdc(4'h0, 32'h0, "ctrl_lane");
        put(4'h5);
        put(4'h4);
        repeat (6) @(posedge i_clk);
        rdc(4'h4, 32'h08, "stalled");
        acc(1'b1, 4'h0, 32'h1);
        repeat (6) @(posedge i_clk);
        @(negedge i_clk) pad(2'b10, "sdr");
        acc(1'b1, 4'h0, 32'h3);
        rdc(4'h0, 32'h1, "ctrl_lock");
        acc(1'b1, 4'h0, 32'h0);
        acc(1'b1, 4'h0, 32'h3);
        rdc(4'h0, 32'h3, "ctrl_ddr");
        foreach (dw[k]) begin
            put(dw[k]);
            repeat (3) @(posedge i_clk);
            #10 pad({dw[k][2], dw[k][0]}, "ddr_hi");
            @(negedge i_clk);
            #10 pad({dw[k][3],dw[k][1]}, "ddr_lo");
        end
        acc(1'b1, 4'h0, 32'h0);
        acc(1'b1, 4'h0, 32'h11);
        put(4'h5);
        repeat (4) @(posedge i_clk);
        rdc(4'h4, 32'h34, "srst_status");
        acc(1'b1, 4'h0, 32'h1);
        repeat (4) @(posedge i_clk);
        @(negedge i_clk) pad(2'b11, "drain");
        acc(1'b1, 4'h0, 32'h0);
        acc(1'b1, 4'h0, 32'hd);
        rdc(4'h0, 32'hd, "ctrl_latch");
        put(4'ha);
        repeat (4) @(posedge i_clk);
        @(negedge i_clk) pad(2'b00, "latch");
        end_of_test;
    end
endmodule // iotr_out_stage_tb_top
